// ==== rtl/output_select_map.svh ====
// Purpose: offsets, reset values and timing counts for the output function selector
// Assumes: 32-bit AXI4-Lite, one register per aligned word
// Notes:   included by the selector and the testbench
`ifndef OUTPUT_SELECT_MAP_SVH
`define OUTPUT_SELECT_MAP_SVH

`define OFS_MUX_MODE        12'h000
`define OFS_SWITCH_FUNC     12'h004
`define OFS_RELAY_ONE_FUNC  12'h008
`define OFS_RELAY_TWO_FUNC  12'h00C
`define OFS_COLL_ONE_FUNC   12'h010
`define OFS_COLL_TWO_FUNC   12'h014
`define OFS_COMM_OUT        12'h018
`define OFS_OUT_STATUS      12'h01C
`define OFS_PULSE_DIV       12'h020

`define RST_MUX_MODE        8'h00
`define RST_SWITCH_FUNC     8'h00
`define RST_RELAY_ONE_FUNC  8'h02
`define RST_RELAY_TWO_FUNC  8'h00
`define RST_COLL_ONE_FUNC   8'h00
`define RST_COLL_TWO_FUNC   8'h04
`define RST_PULSE_DIV       16'h2710

`define FUNC_CODE_MAX       8'h29
`define CLK_HZ              200000000
`define PULSE_MAX_HZ        10000
`define PLC_PULSE_MS        250
`define PLC_PULSE_CYCLES    (`CLK_HZ / 1000 * `PLC_PULSE_MS)
`define PULSE_DIV_MIN       (`CLK_HZ / (2 * `PULSE_MAX_HZ))

`endif

// ==== rtl/output_select_pkg.sv ====
// Purpose: types for the output function selector
// Assumes: constants come from output_select_map.svh
// Notes:   status bundle is the drive condition set
package output_select_pkg;

    typedef struct packed {
        logic running;
        logic fault_stop;
        logic zero_freq;
        logic motor_prealarm;
        logic drive_prealarm;
        logic count_set_hit;
        logic count_desig_hit;
        logic length_hit;
        logic plc_cycle_done;
        logic run_time_hit;
        logic set_freq_limited;
        logic out_freq_limited;
        logic torque_stall;
        logic ready_ok;
        logic analog_one_gt_two;
        logic at_upper_limit;
        logic at_lower_limit;
        logic undervoltage;
    } drive_status_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RESP  = 2'b01
    } bus_state_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [39:0] func;
        logic [4:0]  comm_out;
        logic [15:0] pulse_div;
        logic [4:0]  outs;
        logic [31:0] plc_cnt;
        logic        plc_q;
        logic [15:0] div_cnt;
        logic        pulse_lvl;
        bus_state_t  wst;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } sel_state_t;

endpackage : output_select_pkg

// ==== rtl/output_terminal_function_select.sv ====
// Purpose: route drive conditions onto five digital outputs, AXI4-Lite controlled
// Assumes: drive status and aux inputs synchronous to aclk
// Notes:   output bit order 0 switch, 1 relay one, 2 relay two, 3 coll one, 4 coll two
// What this block does
// - mode 0 pulse, mode 1 switch output
// - pulse mode reaches up to 10kHz
// - five outputs, each code 0-41
// - code 0 keeps output inactive
// - code 1 on while running
// - code 2 on at fault stop
// - code 5 on running at 0Hz
// - code 6 on at motor pre-alarm
// - code 7 on at drive pre-alarm
// - codes 8,9 on at count hits
// - code 10 on past length setpoint
// - code 11 gives 250ms pulse per cycle
// - code 12 on past run-time setpoint
// - code 13 on when both frequencies limited
// - code 14 on at torque stall
// - code 15 on when ready to run
// - code 16 on when analog one exceeds two
// - codes 17,18 upper/lower limit, 18 off stopped
// - code 19 on in under-voltage
// - code 20 from comms; 21,22 reserved
// - code 23 on at 0Hz or stopped
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "output_select_map.svh"

module output_terminal_function_select
    import output_select_pkg::*;
#(
    parameter int unsigned PLC_PULSE_LEN = `PLC_PULSE_CYCLES
)(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [11:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [11:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire drive_status_t drive_status,
    input  wire logic [41:0]   aux_condition,
    output logic               multiplex_output_pin,
    output logic               relay_one_contacts,
    output logic               relay_two_contacts,
    output logic               collector_out_one,
    output logic               collector_out_two
);

    sel_state_t st_reg;
    sel_state_t st_next;
    logic       plc_active;
    logic       wr_go;
    logic       rd_go;

    // pick one output's condition from its selection code
    function automatic logic cond_of(input logic [7:0] code, input drive_status_t s,
                                     input logic plc, input logic comm, input logic [41:0] aux);
        logic c;
        c = 1'b0;
        case (code)
            8'h00: c = 1'b0;
            8'h01: c = s.running;
            8'h02: c = s.fault_stop;
            8'h05: c = s.running & s.zero_freq;
            8'h06: c = s.motor_prealarm;
            8'h07: c = s.drive_prealarm;
            8'h08: c = s.count_set_hit;
            8'h09: c = s.count_desig_hit;
            8'h0A: c = s.length_hit;
            8'h0B: c = plc;
            8'h0C: c = s.run_time_hit;
            8'h0D: c = s.set_freq_limited & s.out_freq_limited;
            8'h0E: c = s.torque_stall;
            8'h0F: c = s.ready_ok;
            8'h10: c = s.analog_one_gt_two;
            8'h11: c = s.at_upper_limit;
            8'h12: c = s.running & s.at_lower_limit;
            8'h13: c = s.undervoltage;
            8'h14: c = comm;
            8'h15: c = 1'b0;
            8'h16: c = 1'b0;
            8'h17: c = s.zero_freq | ~s.running;
            default:
            begin
                // out-of-range codes never get here: writes refuse them and keep the old code
                c = (code <= `FUNC_CODE_MAX) ? aux[code[5:0]] : 1'b0;
            end
        endcase
        return c;
    endfunction : cond_of

    // write data with byte strobes merged over the old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (stb[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction : merge

    assign plc_active    = (st_reg.plc_cnt != 32'h0);
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~st_reg.bvalid;
    assign rd_go         = s_axi_arvalid & ~st_reg.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = st_reg.rdata;

    // next state: bus slave, pulse stretcher, pulse divider and output selection
    always_comb
    begin
        logic [31:0] w;
        logic [7:0]  code;
        logic [31:0] old;
        w    = 32'h0;
        code = 8'h0;
        old  = 32'h0;
        st_next = st_reg;
        st_next.wst = ST_IDLE;
        // write path: both channels taken together, answer one cycle later
        if (wr_go)
        begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = 2'b00;
            case (s_axi_awaddr)
                `OFS_MUX_MODE:      old = {24'h0, st_reg.mode};
                `OFS_SWITCH_FUNC:   old = {24'h0, st_reg.func[7:0]};
                `OFS_RELAY_ONE_FUNC: old = {24'h0, st_reg.func[15:8]};
                `OFS_RELAY_TWO_FUNC: old = {24'h0, st_reg.func[23:16]};
                `OFS_COLL_ONE_FUNC: old = {24'h0, st_reg.func[31:24]};
                `OFS_COLL_TWO_FUNC: old = {24'h0, st_reg.func[39:32]};
                `OFS_COMM_OUT:      old = {27'h0, st_reg.comm_out};
                `OFS_PULSE_DIV:     old = {16'h0, st_reg.pulse_div};
                default:            old = 32'h0;
            endcase
            w = merge(old, s_axi_wdata, s_axi_wstrb);
            // codes above 41 are refused by leaving the old code in place
            code = (w[7:0] <= `FUNC_CODE_MAX) ? w[7:0] : old[7:0];
            case (s_axi_awaddr)
                `OFS_MUX_MODE:       st_next.mode = {7'h0, w[0]};
                `OFS_SWITCH_FUNC:    st_next.func[7:0]   = code;
                `OFS_RELAY_ONE_FUNC: st_next.func[15:8]  = code;
                `OFS_RELAY_TWO_FUNC: st_next.func[23:16] = code;
                `OFS_COLL_ONE_FUNC:  st_next.func[31:24] = code;
                `OFS_COLL_TWO_FUNC:  st_next.func[39:32] = code;
                `OFS_COMM_OUT:       st_next.comm_out = w[4:0];
                `OFS_PULSE_DIV:
                begin
                    // a half period below the floor would exceed 10kHz
                    st_next.pulse_div = (w[15:0] < 16'(`PULSE_DIV_MIN)) ? 16'(`PULSE_DIV_MIN) : w[15:0];
                end
                `OFS_OUT_STATUS:     st_next.bresp = 2'b10;           // read-only
                default:             st_next.bresp = 2'b10;           // unmapped
            endcase
        end
        else if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        // read path: answer one cycle after the address is taken
        if (rd_go)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = 2'b00;
            case (s_axi_araddr)
                `OFS_MUX_MODE:       st_next.rdata = {24'h0, st_reg.mode};
                `OFS_SWITCH_FUNC:    st_next.rdata = {24'h0, st_reg.func[7:0]};
                `OFS_RELAY_ONE_FUNC: st_next.rdata = {24'h0, st_reg.func[15:8]};
                `OFS_RELAY_TWO_FUNC: st_next.rdata = {24'h0, st_reg.func[23:16]};
                `OFS_COLL_ONE_FUNC:  st_next.rdata = {24'h0, st_reg.func[31:24]};
                `OFS_COLL_TWO_FUNC:  st_next.rdata = {24'h0, st_reg.func[39:32]};
                `OFS_COMM_OUT:       st_next.rdata = {27'h0, st_reg.comm_out};
                `OFS_OUT_STATUS:     st_next.rdata = {27'h0, st_reg.outs};
                `OFS_PULSE_DIV:      st_next.rdata = {16'h0, st_reg.pulse_div};
                default:
                begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = 2'b10;
                end
            endcase
        end
        else if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
        // one 250ms pulse per completed cycle; a new completion restarts it
        st_next.plc_q = drive_status.plc_cycle_done;
        if (drive_status.plc_cycle_done && !st_reg.plc_q)
            st_next.plc_cnt = PLC_PULSE_LEN;
        else if (plc_active)
            st_next.plc_cnt = st_reg.plc_cnt - 32'h1;
        // square wave for pulse mode, half period in aclk cycles
        if (st_reg.mode[0] || st_reg.div_cnt >= st_reg.pulse_div - 16'h1)
        begin
            st_next.div_cnt = 16'h0;
            st_next.pulse_lvl = st_reg.mode[0] ? 1'b0 : ~st_reg.pulse_lvl;
        end
        else
            st_next.div_cnt = st_reg.div_cnt + 16'h1;
        // registered outputs, one selection per terminal
        for (int i = 0; i < 5; i++)
            st_next.outs[i] = cond_of(st_reg.func[i*8 +: 8], drive_status, plc_active,
                                      st_reg.comm_out[i], aux_condition);
    end

    // state register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.mode <= `RST_MUX_MODE;
            st_reg.func <= {`RST_COLL_TWO_FUNC, `RST_COLL_ONE_FUNC, `RST_RELAY_TWO_FUNC,
                            `RST_RELAY_ONE_FUNC, `RST_SWITCH_FUNC};
            st_reg.pulse_div <= `RST_PULSE_DIV;
        end
        else
            st_reg <= st_next;
    end

    // multiplexed pin: pulse train in mode 0, switch level in mode 1
    assign multiplex_output_pin = st_reg.mode[0] ? st_reg.outs[0] : st_reg.pulse_lvl;
    assign relay_one_contacts   = st_reg.outs[1];
    assign relay_two_contacts   = st_reg.outs[2];
    assign collector_out_one    = st_reg.outs[3];
    assign collector_out_two    = st_reg.outs[4];

    // one clock domain: every check below samples on aclk and sleeps in reset
    default clocking main_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // completion pulse start; the check below holds it for 8 cycles, not the whole width
    sequence plc_start_s;
        drive_status.plc_cycle_done && !st_reg.plc_q;
    endsequence

    // a write taken on both channels, and a read taken on its own
    sequence wr_take_s;
        wr_go;
    endsequence

    sequence rd_take_s;
        rd_go;
    endsequence

    a_mux_mode_pulse: assert property (
        !st_reg.mode[0] |-> multiplex_output_pin == st_reg.pulse_lvl)
        else $error("pulse mode pin not following pulse train");

    // the pin may only change when the half-period counter wraps
    a_pulse_half_hold: assert property (
        !st_reg.mode[0] && !wr_go && st_reg.div_cnt < st_reg.pulse_div - 16'h1 |=>
        $stable(multiplex_output_pin))
        else $error("pulse level changed inside a half period");

    a_pulse_rate_max: assert property (
        st_reg.pulse_div >= 16'(`PULSE_DIV_MIN))
        else $error("pulse divider allows over 10kHz");

    a_code_range_ok: assert property (
        st_reg.func[7:0] <= `FUNC_CODE_MAX && st_reg.func[15:8] <= `FUNC_CODE_MAX)
        else $error("selection code out of range");

    a_code_zero_off: assert property (
        st_reg.func[15:8] == 8'h00 && $stable(st_reg.func[15:8]) |=> !relay_one_contacts)
        else $error("code 0 output active");

    a_run_follow_on: assert property (
        st_reg.func[15:8] == 8'h01 |=> relay_one_contacts == $past(drive_status.running))
        else $error("code 1 not following running");

    a_fault_follow_on: assert property (
        st_reg.func[15:8] == 8'h02 |=> relay_one_contacts == $past(drive_status.fault_stop))
        else $error("code 2 not following fault stop");

    a_null_run_on: assert property (
        st_reg.func[7:0] == 8'h05 |=>
        st_reg.outs[0] == $past(drive_status.running & drive_status.zero_freq))
        else $error("code 5 not on while running at 0Hz");

    a_motor_pre_on: assert property (
        st_reg.func[15:8] == 8'h06 |=>
        st_reg.outs[1] == $past(drive_status.motor_prealarm))
        else $error("code 6 not following motor pre-alarm");

    a_drive_pre_on: assert property (
        st_reg.func[23:16] == 8'h07 |=>
        st_reg.outs[2] == $past(drive_status.drive_prealarm))
        else $error("code 7 not following drive pre-alarm");

    a_count_hit_on: assert property (
        st_reg.func[31:24] == 8'h08 |=>
        st_reg.outs[3] == $past(drive_status.count_set_hit))
        else $error("code 8 not following count hit");

    a_length_hit_on: assert property (
        st_reg.func[7:0] == 8'h0A |=>
        st_reg.outs[0] == $past(drive_status.length_hit))
        else $error("code 10 not following length hit");

    a_run_time_on: assert property (
        st_reg.func[23:16] == 8'h0C |=>
        st_reg.outs[2] == $past(drive_status.run_time_hit))
        else $error("code 12 not following run time");

    a_freq_limit_on: assert property (
        st_reg.func[31:24] == 8'h0D |=>
        st_reg.outs[3] == $past(drive_status.set_freq_limited & drive_status.out_freq_limited))
        else $error("code 13 not following both limits");

    a_ready_run_on: assert property (
        st_reg.func[7:0] == 8'h0F |=>
        st_reg.outs[0] == $past(drive_status.ready_ok))
        else $error("code 15 not following ready");

    a_analog_cmp_on: assert property (
        st_reg.func[15:8] == 8'h10 |=>
        st_reg.outs[1] == $past(drive_status.analog_one_gt_two))
        else $error("code 16 not following analog compare");

    a_undervolt_on: assert property (
        st_reg.func[39:32] == 8'h13 |=>
        st_reg.outs[4] == $past(drive_status.undervoltage))
        else $error("code 19 not following under-voltage");

    a_aux_code_on: assert property (
        st_reg.func[39:32] == 8'h18 |=>
        st_reg.outs[4] == $past(aux_condition[24]))
        else $error("code 24 not following its status input");

    // the bus answers one cycle after taking a request
    a_write_answer: assert property (
        wr_take_s |=> s_axi_bvalid)
        else $error("write taken without a response");

    a_read_answer: assert property (
        rd_take_s |=> s_axi_rvalid)
        else $error("read taken without a response");

    a_plc_pulse_hold: assert property (
        plc_start_s |=> plc_active [*8])
        else $error("completion pulse too short");

    a_stop_zero_on: assert property (
        st_reg.func[15:8] == 8'h17 && !drive_status.running |=> relay_one_contacts)
        else $error("code 23 not on while stopped");

endmodule : output_terminal_function_select
`default_nettype wire

// ==== tb/output_load_model.sv ====
// Purpose: load model on the multiplexed pin, times the pulse train
// Assumes: pin level sampled on aclk, loads only listen and never drive
// Notes:   counts level changes and keeps the length of the last full high phase
`timescale 1ns/1ps
`default_nettype none
module output_load_model (
    input  wire logic aclk,
    input  wire logic pin,
    output int        edges,
    output int        last_high
);
    int   run      = 0;
    int   edge_cnt = 0;
    int   high_len = 0;
    logic prev     = 1'b0;

    // one driver per output: the counters live here and are only mirrored out
    assign edges     = edge_cnt;
    assign last_high = high_len;

    // a high phase is latched when it ends, so a partial phase is overwritten later
    always @(posedge aclk)
    begin
        prev <= pin;
        if (pin != prev) edge_cnt <= edge_cnt + 1;
        if (pin) run <= prev ? run + 1 : 1;
        if (!pin && prev) high_len <= run;
    end
endmodule : output_load_model
`default_nettype wire

// ==== tb/output_terminal_function_select_tb.sv ====
// Purpose: self-checking bench for the output function selector
// Assumes: short PLC pulse parameter, registers over AXI4-Lite
// Notes:   random status from a fixed LFSR seed, code sweep covers all 42 codes but 11
`timescale 1ns/1ps
`default_nettype none
`include "output_select_map.svh"
module output_terminal_function_select_tb;
    import output_select_pkg::*;
    localparam int PLC_LEN = 20;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid;
    drive_status_t status = '0, st;
    logic [41:0] aux_in = '0, aux;
    logic [4:0]  pins, exp_o, comm;
    logic [15:0] seed = 16'h6425;  // 25637
    logic [15:0] v;
    int          bad_count = 0, total_checks = 0, it, i, n, e0, code [5];
    wire         p0, p1, p2, p3, p4;
    int          edges, last_high;

    always #2.5 aclk = ~aclk;
    assign pins = {p4, p3, p2, p1, p0};

    output_terminal_function_select #(.PLC_PULSE_LEN(PLC_LEN)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_status(status),
        .aux_condition(aux_in), .multiplex_output_pin(p0), .relay_one_contacts(p1),
        .relay_two_contacts(p2), .collector_out_one(p3), .collector_out_two(p4));

    output_load_model load_u (.aclk(aclk), .pin(p0), .edges(edges), .last_high(last_high));

    // galois-free shift register, tap set gives a maximal sequence
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic rnd(output logic [15:0] o);
        seed = lfsr(seed);
        o = seed;
    endtask : rnd

    // expected output level for one selection code
    function automatic logic expect_out(input int c, input drive_status_t s, input logic [41:0] ax,
                                        input logic cm);
        case (c)
            1: return s.running;
            2: return s.fault_stop;
            5: return s.running & s.zero_freq;
            6: return s.motor_prealarm;
            7: return s.drive_prealarm;
            8: return s.count_set_hit;
            9: return s.count_desig_hit;
            10: return s.length_hit;
            12: return s.run_time_hit;
            13: return s.set_freq_limited & s.out_freq_limited;
            14: return s.torque_stall;
            15: return s.ready_ok;
            16: return s.analog_one_gt_two;
            17: return s.at_upper_limit;
            18: return s.running & s.at_lower_limit;
            19: return s.undervoltage;
            20: return cm;
            23: return s.zero_freq | ~s.running;
            0, 11, 21, 22: return 1'b0;
            default: return ax[c];
        endcase
    endfunction : expect_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // a used-up wait counts as a mismatch and ends the run
    task automatic expire(input int cnt, input int lim);
        if (cnt >= lim)
        begin
            bad_count++;
            $display("BAD at %0t: wait ran out", $time);
            stop_test();
        end
    endtask : expire

    // one edge first so a release at the previous call never collides with a new request
    task automatic axi_write(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= wd;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        expire(n, 50);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        expire(n, 50);
    endtask : axi_read

    task automatic rd_expect(input logic [11:0] a, input logic [31:0] e);
        axi_read(a, d, r);
        check(d, e);
        check(32'(r), 32'h0);
    endtask : rd_expect

    // waits for three level changes so one full high phase of the new rate is seen
    task automatic wait_edges();
        e0 = edges;
        for (it = 0; it < 40000 && edges < e0 + 3; it++) @(posedge aclk);
        expire(it, 40000);
    endtask : wait_edges

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_expect(`OFS_MUX_MODE, 32'h0);
        rd_expect(`OFS_SWITCH_FUNC, 32'h0);
        rd_expect(`OFS_RELAY_ONE_FUNC, 32'h2);
        rd_expect(`OFS_RELAY_TWO_FUNC, 32'h0);
        rd_expect(`OFS_COLL_ONE_FUNC, 32'h0);
        rd_expect(`OFS_COLL_TWO_FUNC, 32'h4);
        axi_read(12'h040, d, r);
        check(d, 32'h0);
        check(32'(r), 32'h2);
        axi_write(`OFS_OUT_STATUS, 32'h1F, r);
        check(32'(r), 32'h2);
        axi_write(`OFS_RELAY_TWO_FUNC, 32'h2A, r);  // above the top code, kept old
        rd_expect(`OFS_RELAY_TWO_FUNC, 32'h0);
        axi_write(`OFS_RELAY_TWO_FUNC, 32'h29, r);
        rd_expect(`OFS_RELAY_TWO_FUNC, 32'h29);
        $display("register test done");
        // pulse mode: a divider below the 10kHz limit is clamped
        axi_write(`OFS_PULSE_DIV, 32'd5000, r);
        rd_expect(`OFS_PULSE_DIV, 32'd10000);
        wait_edges();
        check(32'(last_high), 32'd10000);
        axi_write(`OFS_PULSE_DIV, 32'd12000, r);
        wait_edges();
        check(32'(last_high), 32'd12000);
        $display("pulse test done");
        // switch mode, every code but 11 on some output against random status
        axi_write(`OFS_MUX_MODE, 32'h1, r);
        for (it = 0; it < 18; it++)
        begin
            for (i = 0; i < 5; i++)
            begin
                code[i] = (it * 5 + i) % 42;
                if (code[i] == 11) code[i] = 1;
                axi_write(12'(`OFS_SWITCH_FUNC + 4 * i), 32'(code[i]), r);
            end
            rnd(v);
            comm = v[4:0];
            axi_write(`OFS_COMM_OUT, {27'h0, comm}, r);
            rnd(v);
            st = drive_status_t'({v, seed[3:2]});
            st.plc_cycle_done = 1'b0;
            rnd(v);
            aux = {v[9:0], seed, lfsr(seed)};
            status <= st;
            aux_in <= aux;
            repeat (3) @(posedge aclk);
            for (i = 0; i < 5; i++) exp_o[i] = expect_out(code[i], st, aux, comm[i]);
            check(32'(pins), 32'(exp_o));
            axi_read(`OFS_OUT_STATUS, d, r);
            check(d, 32'(exp_o));
        end
        $display("code sweep done");
        // one pulse of fixed width per completed cycle, even with the level held
        for (i = 0; i < 5; i++) axi_write(12'(`OFS_SWITCH_FUNC + 4 * i), (i == 1) ? 32'd11 : 32'd0, r);
        status <= '0;
        repeat (3) @(posedge aclk);
        status.plc_cycle_done <= 1'b1;
        e0 = 0;
        repeat (3 * PLC_LEN)
        begin
            @(posedge aclk);
            if (p1 === 1'b1) e0++;
        end
        check(32'(e0), 32'(PLC_LEN));
        $display("cycle pulse test done");
        stop_test();
    end
endmodule : output_terminal_function_select_tb
`default_nettype wire
